// >>> rtl/cpurf_defines.svh
// Offsets, field positions, reset values and vectors of the CPU register file
`ifndef CPURF_DEFINES_SVH
`define CPURF_DEFINES_SVH

// Register byte offsets on the bus
`define CPURF_OFS_ACC     8'h00
`define CPURF_OFS_INDEX   8'h04
`define CPURF_OFS_STACK   8'h08
`define CPURF_OFS_PC      8'h0c
`define CPURF_OFS_FLAGS   8'h10
`define CPURF_OFS_CMD     8'h14
`define CPURF_OFS_STATUS  8'h18

// Condition flag bit positions
`define CPURF_CF_V        7
`define CPURF_CF_H        4
`define CPURF_CF_I        3
`define CPURF_CF_N        2
`define CPURF_CF_Z        1
`define CPURF_CF_C        0
`define CPURF_CF_ONES     8'h60

// Command register fields
`define CPURF_CMD_OP_MSB  5
`define CPURF_CMD_OPD_LSB 16

// Reset values and vectors
`define CPURF_RST_HIGH    8'h00
`define CPURF_RST_SP      16'h00ff
`define CPURF_RST_FLAGS   8'h68
`define CPURF_VEC_HI      16'hfffe
`define CPURF_VEC_LO      16'hffff
`define CPURF_RSP_LOW     8'hff

// Stack push byte indices
`define CPURF_PB_PCL      3'h0
`define CPURF_PB_PCH      3'h1
`define CPURF_PB_X        3'h2
`define CPURF_PB_A        3'h3
`define CPURF_PB_CCR      3'h4

`endif

// >>> rtl/cpurf_pkg.sv
// Types shared by the CPU register file
package cpurf_pkg;

    typedef enum logic [5:0] {
        OP_NOP, OP_ADD, OP_ADC, OP_SUB, OP_DAA, OP_LDA, OP_STA, OP_LDHX,
        OP_CLRX, OP_INCX, OP_DECX, OP_COMX, OP_NEGX, OP_LSLX, OP_RORX,
        OP_AIS, OP_RSP, OP_PSHA, OP_PULA, OP_CALL, OP_INTR, OP_RTS,
        OP_JMP, OP_BRA, OP_BSG, OP_BSL, OP_FETCH,
        OP_EADIR, OP_EAEXT, OP_EAIMM, OP_EAIX, OP_EAIX1, OP_EAIX2,
        OP_EAIXP, OP_EAIX1P, OP_WAIT, OP_STOP
    } cpurf_op_e;

    typedef enum logic [2:0] {
        ST_VEC1, ST_VEC2, ST_VEC3, ST_IDLE, ST_PUSH, ST_RDWT, ST_RDDT
    } cpurf_state_e;

    typedef enum logic [1:0] {DST_A, DST_PCH, DST_PCL, DST_FETCH} cpurf_dst_e;

    typedef enum logic [1:0] {LP_RUN, LP_WAIT, LP_STOP} cpurf_lp_e;

    typedef struct packed {
        logic [7:0] res;
        logic       v;
        logic       h;
        logic       c;
    } cpurf_alu_s;

    typedef struct packed {
        logic        re;
        logic        we;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } cpurf_mem_s;

    typedef struct packed {
        logic        hreadyout;
        logic        hresp;
        logic [31:0] hrdata;
    } cpurf_ahbo_s;

    typedef struct packed {
        logic [7:0]   acc;
        logic [15:0]  hx;
        logic [15:0]  sp;
        logic [15:0]  pc;
        logic [7:0]   flags;
        logic [15:0]  ea;
        logic [7:0]   fetchByte;
        cpurf_state_e st;
        cpurf_dst_e   dst;
        logic [2:0]   pushIdx;
        logic [2:0]   pushEnd;
        logic         isIntr;
        logic [15:0]  target;
        cpurf_lp_e    lp;
        logic         taken;
        cpurf_mem_s   mem;
        cpurf_ahbo_s  bus;
        logic         pend;
        logic         pendWr;
        logic [7:0]   pendAddr;
    } cpurf_state_s;

endpackage

// >>> rtl/cpurf_core.sv
// CPU programmer-visible register file with AHB-Lite register access
//
// Overview of operation
// - Eight-bit accumulator, untouched by reset.
// - Index pointer is high and low bytes; indexed modes use all sixteen bits.
// - Reset clears index high byte; low byte keeps its value.
// - Low index byte clears, increments, decrements, complements, negates, shifts, rotates.
// - Sixteen-bit stack pointer addresses next free stack location anywhere.
// - Reset loads stack pointer with 0x00FF.
// - Stack adjust adds sign-extended eight-bit immediate to stack pointer.
// - Stack low reset changes only the low stack pointer byte.
// - Program counter advances by one on every byte fetch.
// - Jumps, branches, interrupts and returns load a non-sequential address.
// - After reset the program counter loads from 0xFFFE high, 0xFFFF low.
// - Flag bits 6 and 5 always read one.
// - Overflow flag bit 7 on signed overflow; signed branches test it.
// - Half-carry bit 4 set on carry from bit 3 in adds, else cleared.
// - Decimal adjust uses half-carry and carry to correct a BCD add.
// - Direct addressing reaches only 0x0000 through 0x00FF with one byte.
// - Relative branch target is program counter plus signed eight-bit offset.
// - Extended addressing takes a full sixteen-bit address anywhere.
// - Five indexed submodes, two post-incrementing the index pointer.
// - Immediate operand comes from bytes directly after the opcode.
// - Calls stack return address; interrupts stack it plus registers.
// - Dedicated commands enter the two low-power states.
// - Interrupt mask bit 3 blocks interrupts; set after stacking on entry.
// - Negative flag follows result bit 7, loads and stores included; the index load takes it from bit 15.
// - Zero flag set on all-zero result, load or store, else cleared.
// - Carry flag bit 0 is carry out of bit 7 or borrow.
//
// Implementation choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`include "cpurf_defines.svh"

module cpurf_core
    import cpurf_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic [7:0]  memRdata,
    output logic [15:0]      memAddr,
    output logic [7:0]       memWdata,
    output logic             memRe,
    output logic             memWe,
    output logic [1:0]       lowPowerMode
);

    cpurf_state_s s_reg;
    cpurf_state_s s_next;

    // Add or subtract with carry, half-carry and overflow
    function automatic cpurf_alu_s alu8(logic [7:0] a, logic [7:0] b, logic cin, logic sub);
        logic [7:0] bb;
        logic [8:0] sum;
        logic [4:0] lo;
        bb = sub ? ~b : b;
        sum = {1'b0, a} + {1'b0, bb} + {8'h00, cin};
        lo = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
        alu8.res = sum[7:0];
        alu8.h = lo[4];
        alu8.c = sub ? ~sum[8] : sum[8];
        alu8.v = (a[7] == bb[7]) && (sum[7] != a[7]);
    endfunction

    // Negative, zero and overflow update for an 8-bit result
    function automatic logic [7:0] nzv8(logic [7:0] f, logic [7:0] r, logic v);
        nzv8 = f;
        nzv8[`CPURF_CF_N] = r[7];
        nzv8[`CPURF_CF_Z] = (r == 8'h00);
        nzv8[`CPURF_CF_V] = v;
    endfunction

    // Sign extension of a byte offset
    function automatic logic [15:0] sext8(logic [7:0] b);
        sext8 = {{8{b[7]}}, b};
    endfunction

    // Byte stacked at a given push step
    function automatic logic [7:0] pushByte(cpurf_state_s c, logic [2:0] idx);
        case (idx)
            `CPURF_PB_PCL: pushByte = c.pc[7:0];
            `CPURF_PB_PCH: pushByte = c.pc[15:8];
            `CPURF_PB_X:   pushByte = c.hx[7:0];
            `CPURF_PB_A:   pushByte = c.acc;
            default:       pushByte = c.flags;
        endcase
    endfunction

    // Register read multiplexer
    function automatic logic [31:0] readMux(cpurf_state_s c, logic [7:0] a);
        case (a)
            `CPURF_OFS_ACC:    readMux = {24'h000000, c.acc};
            `CPURF_OFS_INDEX:  readMux = {16'h0000, c.hx};
            `CPURF_OFS_STACK:  readMux = {16'h0000, c.sp};
            `CPURF_OFS_PC:     readMux = {16'h0000, c.pc};
            `CPURF_OFS_FLAGS:  readMux = {24'h000000, c.flags};
            `CPURF_OFS_STATUS: readMux = {c.ea, c.fetchByte, 4'h0, c.taken, c.lp,
                                          c.st != ST_IDLE};
            default:           readMux = 32'h00000000;
        endcase
    endfunction

    logic       cmdGo;
    cpurf_op_e  op;
    logic [15:0] opd;
    cpurf_alu_s r;
    logic [7:0] corr;
    logic [8:0] dsum;

    // Command decode from the write data phase
    always_comb begin
        cmdGo = s_reg.pend && s_reg.pendWr && (s_reg.pendAddr == `CPURF_OFS_CMD)
                && (s_reg.st == ST_IDLE);
        op = cpurf_op_e'(hwdata[`CPURF_CMD_OP_MSB:0]);
        opd = hwdata[31:`CPURF_CMD_OPD_LSB];
    end

    // Next-state logic
    always_comb begin
        s_next = s_reg;
        s_next.mem.re = 1'b0;
        s_next.mem.we = 1'b0;
        r = '0;
        corr = 8'h00;
        dsum = 9'h000;

        // Bus slave: one wait state, then write or read data
        if (s_reg.pend) begin
            s_next.pend = 1'b0;
            s_next.bus.hreadyout = 1'b1;
            if (!s_reg.pendWr) begin
                s_next.bus.hrdata = readMux(s_reg, s_reg.pendAddr);
            end else if (s_reg.st == ST_IDLE) begin
                case (s_reg.pendAddr)
                    `CPURF_OFS_ACC:   s_next.acc = hwdata[7:0];
                    `CPURF_OFS_INDEX: s_next.hx = hwdata[15:0];
                    `CPURF_OFS_STACK: s_next.sp = hwdata[15:0];
                    `CPURF_OFS_PC:    s_next.pc = hwdata[15:0];
                    `CPURF_OFS_FLAGS: s_next.flags = hwdata[7:0];
                    default:          s_next.pendWr = 1'b0;
                endcase
            end
        end else if (hsel && htrans[1] && hready) begin
            s_next.pend = 1'b1;
            s_next.pendWr = hwrite;
            s_next.pendAddr = haddr[7:0];
            s_next.bus.hreadyout = 1'b0;
        end

        // Command execution
        if (cmdGo) begin
            s_next.lp = LP_RUN;
            s_next.taken = 1'b0;
            case (op)
                OP_ADD, OP_ADC: begin
                    r = alu8(s_reg.acc, opd[7:0],
                             (op == OP_ADC) && s_reg.flags[`CPURF_CF_C], 1'b0);
                    s_next.acc = r.res;
                    s_next.flags = nzv8(s_reg.flags, r.res, r.v);
                    s_next.flags[`CPURF_CF_H] = r.h;
                    s_next.flags[`CPURF_CF_C] = r.c;
                end
                OP_SUB: begin
                    r = alu8(s_reg.acc, opd[7:0], 1'b1, 1'b1);
                    s_next.acc = r.res;
                    s_next.flags = nzv8(s_reg.flags, r.res, r.v);
                    s_next.flags[`CPURF_CF_C] = r.c;
                end
                OP_DAA: begin
                    if (s_reg.flags[`CPURF_CF_H] || (s_reg.acc[3:0] > 4'h9)) begin
                        corr[3:0] = 4'h6;
                    end
                    if (s_reg.flags[`CPURF_CF_C] || (s_reg.acc > 8'h99)) begin
                        corr[7:4] = 4'h6;
                    end
                    dsum = {1'b0, s_reg.acc} + {1'b0, corr};
                    s_next.acc = dsum[7:0];
                    s_next.flags = nzv8(s_reg.flags, dsum[7:0], s_reg.flags[`CPURF_CF_V]);
                    s_next.flags[`CPURF_CF_C] = s_reg.flags[`CPURF_CF_C] | corr[6];
                end
                OP_LDA: begin
                    s_next.acc = opd[7:0];
                    s_next.flags = nzv8(s_reg.flags, opd[7:0], 1'b0);
                end
                OP_STA: begin
                    s_next.mem.we = 1'b1;
                    s_next.mem.addr = s_reg.ea;
                    s_next.mem.wdata = s_reg.acc;
                    s_next.flags = nzv8(s_reg.flags, s_reg.acc, 1'b0);
                end
                OP_LDHX: begin
                    s_next.hx = opd;
                    s_next.flags[`CPURF_CF_N] = opd[15];
                    s_next.flags[`CPURF_CF_Z] = (opd == 16'h0000);
                    s_next.flags[`CPURF_CF_V] = 1'b0;
                end
                OP_CLRX: begin
                    s_next.hx[7:0] = 8'h00;
                    s_next.flags = nzv8(s_reg.flags, 8'h00, 1'b0);
                end
                OP_INCX, OP_DECX, OP_NEGX: begin
                    if (op == OP_NEGX) begin
                        r = alu8(8'h00, s_reg.hx[7:0], 1'b1, 1'b1);
                    end else begin
                        r = alu8(s_reg.hx[7:0], 8'h01, op == OP_DECX, op == OP_DECX);
                    end
                    s_next.hx[7:0] = r.res;
                    s_next.flags = nzv8(s_reg.flags, r.res, r.v);
                    if (op == OP_NEGX) begin
                        s_next.flags[`CPURF_CF_C] = r.c;
                    end
                end
                OP_COMX: begin
                    s_next.hx[7:0] = ~s_reg.hx[7:0];
                    s_next.flags = nzv8(s_reg.flags, ~s_reg.hx[7:0], 1'b0);
                    s_next.flags[`CPURF_CF_C] = 1'b1;
                end
                OP_LSLX: begin
                    s_next.hx[7:0] = {s_reg.hx[6:0], 1'b0};
                    s_next.flags = nzv8(s_reg.flags, {s_reg.hx[6:0], 1'b0},
                                        s_reg.hx[7] ^ s_reg.hx[6]);
                    s_next.flags[`CPURF_CF_C] = s_reg.hx[7];
                end
                OP_RORX: begin
                    s_next.hx[7:0] = {s_reg.flags[`CPURF_CF_C], s_reg.hx[7:1]};
                    s_next.flags = nzv8(s_reg.flags, {s_reg.flags[`CPURF_CF_C],
                                        s_reg.hx[7:1]},
                                        s_reg.flags[`CPURF_CF_C] ^ s_reg.hx[0]);
                    s_next.flags[`CPURF_CF_C] = s_reg.hx[0];
                end
                OP_AIS: s_next.sp = s_reg.sp + sext8(opd[7:0]);
                OP_RSP: s_next.sp[7:0] = `CPURF_RSP_LOW;
                OP_PSHA, OP_CALL, OP_INTR: begin
                    if (!(op == OP_INTR && s_reg.flags[`CPURF_CF_I])) begin
                        s_next.st = ST_PUSH;
                        s_next.isIntr = (op == OP_INTR);
                        s_next.target = (op == OP_PSHA) ? s_reg.pc : opd;
                        s_next.pushIdx = (op == OP_PSHA) ? `CPURF_PB_A : `CPURF_PB_PCL;
                        s_next.pushEnd = (op == OP_PSHA) ? `CPURF_PB_A :
                                         (op == OP_CALL) ? `CPURF_PB_PCH : `CPURF_PB_CCR;
                        s_next.taken = 1'b1;
                    end
                end
                OP_PULA, OP_RTS: begin
                    s_next.mem.re = 1'b1;
                    s_next.mem.addr = s_reg.sp + 16'h0001;
                    s_next.sp = s_reg.sp + 16'h0001;
                    s_next.dst = (op == OP_RTS) ? DST_PCH : DST_A;
                    s_next.st = ST_RDWT;
                end
                OP_JMP: s_next.pc = opd;
                OP_BRA, OP_BSG, OP_BSL: begin
                    if ((op == OP_BRA)
                        || (op == OP_BSG && !(s_reg.flags[`CPURF_CF_Z]
                            || (s_reg.flags[`CPURF_CF_N] ^ s_reg.flags[`CPURF_CF_V])))
                        || (op == OP_BSL
                            && (s_reg.flags[`CPURF_CF_N] ^ s_reg.flags[`CPURF_CF_V]))) begin
                        s_next.pc = s_reg.pc + sext8(opd[7:0]);
                        s_next.taken = 1'b1;
                    end
                end
                OP_FETCH: begin
                    s_next.mem.re = 1'b1;
                    s_next.mem.addr = s_reg.pc;
                    s_next.pc = s_reg.pc + 16'h0001;
                    s_next.dst = DST_FETCH;
                    s_next.st = ST_RDWT;
                end
                OP_EADIR:  s_next.ea = {8'h00, opd[7:0]};
                OP_EAEXT:  s_next.ea = opd;
                OP_EAIMM: begin
                    s_next.ea = s_reg.pc;
                    s_next.pc = s_reg.pc + 16'h0001;
                end
                OP_EAIX:   s_next.ea = s_reg.hx;
                OP_EAIX1:  s_next.ea = s_reg.hx + {8'h00, opd[7:0]};
                OP_EAIX2:  s_next.ea = s_reg.hx + opd;
                OP_EAIXP, OP_EAIX1P: begin
                    s_next.ea = s_reg.hx + ((op == OP_EAIX1P) ? {8'h00, opd[7:0]} : 16'h0000);
                    s_next.hx = s_reg.hx + 16'h0001;
                end
                OP_WAIT:   s_next.lp = LP_WAIT;
                OP_STOP:   s_next.lp = LP_STOP;
                default:   s_next.taken = 1'b0;
            endcase
        end

        // Sequencer: vector load, stacking and memory reads
        case (s_reg.st)
            ST_VEC1: begin
                s_next.mem.re = 1'b1;
                s_next.mem.addr = `CPURF_VEC_LO;
                s_next.st = ST_VEC2;
            end
            ST_VEC2: begin
                s_next.pc[15:8] = memRdata;
                s_next.st = ST_VEC3;
            end
            ST_VEC3: begin
                s_next.pc[7:0] = memRdata;
                s_next.st = ST_IDLE;
            end
            ST_PUSH: begin
                s_next.mem.we = 1'b1;
                s_next.mem.addr = s_reg.sp;
                s_next.mem.wdata = pushByte(s_reg, s_reg.pushIdx);
                s_next.sp = s_reg.sp - 16'h0001;
                s_next.pushIdx = s_reg.pushIdx + 3'h1;
                if (s_reg.pushIdx == s_reg.pushEnd) begin
                    s_next.st = ST_IDLE;
                    s_next.pc = s_reg.target;
                    if (s_reg.isIntr) begin
                        s_next.flags[`CPURF_CF_I] = 1'b1;
                    end
                end
            end
            ST_RDWT: s_next.st = ST_RDDT;
            ST_RDDT: begin
                s_next.st = ST_IDLE;
                case (s_reg.dst)
                    DST_A:   s_next.acc = memRdata;
                    DST_PCH: begin
                        s_next.pc[15:8] = memRdata;
                        s_next.mem.re = 1'b1;
                        s_next.mem.addr = s_reg.sp + 16'h0001;
                        s_next.sp = s_reg.sp + 16'h0001;
                        s_next.dst = DST_PCL;
                        s_next.st = ST_RDWT;
                    end
                    DST_PCL: s_next.pc[7:0] = memRdata;
                    default: s_next.fetchByte = memRdata;
                endcase
            end
            default: ;  // Idle keeps the state the command decode chose
        endcase

        s_next.flags = s_next.flags | `CPURF_CF_ONES;
        s_next.bus.hresp = 1'b0;
    end

    // State register; accumulator and low index byte survive reset
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            s_reg.acc <= s_reg.acc;
            s_reg.hx <= {`CPURF_RST_HIGH, s_reg.hx[7:0]};
            s_reg.sp <= `CPURF_RST_SP;
            s_reg.pc <= 16'h0000;
            s_reg.flags <= `CPURF_RST_FLAGS;
            s_reg.ea <= 16'h0000;
            s_reg.fetchByte <= 8'h00;
            s_reg.st <= ST_VEC1;
            s_reg.dst <= DST_A;
            s_reg.pushIdx <= 3'h0;
            s_reg.pushEnd <= 3'h0;
            s_reg.isIntr <= 1'b0;
            s_reg.target <= 16'h0000;
            s_reg.lp <= LP_RUN;
            s_reg.taken <= 1'b0;
            s_reg.mem <= '{re: 1'b1, we: 1'b0, addr: `CPURF_VEC_HI, wdata: 8'h00};
            s_reg.bus <= '{hreadyout: 1'b1, hresp: 1'b0, hrdata: 32'h00000000};
            s_reg.pend <= 1'b0;
            s_reg.pendWr <= 1'b0;
            s_reg.pendAddr <= 8'h00;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from the state register
    assign hreadyout = s_reg.bus.hreadyout;
    assign hresp = s_reg.bus.hresp;
    assign hrdata = s_reg.bus.hrdata;
    assign memAddr = s_reg.mem.addr;
    assign memWdata = s_reg.mem.wdata;
    assign memRe = s_reg.mem.re;
    assign memWe = s_reg.mem.we;
    assign lowPowerMode = s_reg.lp;

endmodule // cpurf_core

// >>> tb/cpurf_mem_model.sv
// Byte memory on the far side of the register file
`timescale 1ns/100ps
module cpurf_mem_model (
    input  wire logic        core_clk,
    input  wire logic [15:0] memAddr,
    input  wire logic [7:0]  memWdata,
    input  wire logic        memRe,
    input  wire logic        memWe,
    output logic      [7:0]  memRdata
);
    logic [7:0] mem [0:65535];
    // Answer one cycle after the read strobe, garbage otherwise
    always @(posedge core_clk) begin
        if (memRe) begin
            memRdata <= mem[memAddr];
        end else begin
            memRdata <= (memRdata === 8'he1) ? 8'h1e : 8'he1;
        end
        if (memWe) begin
            mem[memAddr] <= memWdata;
        end
    end
endmodule // cpurf_mem_model

// >>> tb/cpurf_core_monitor.sv
// Port checks for the CPU register file
`timescale 1ns/100ps
module cpurf_core_monitor (
    input wire logic        core_clk,
    input wire logic        rstn,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic [15:0] memAddr,
    input wire logic        memRe,
    input wire logic        memWe,
    input wire logic [1:0]  lowPowerMode
);
    // All checks on the core clock, muted in reset
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    property p_vec_hi; $rose(rstn) |-> memRe && memAddr == 16'hfffe; endproperty
    a_vec_hi: assert property (p_vec_hi) else $error("no high vector read");
    property p_vec_lo; $rose(rstn) |=> memRe && memAddr == 16'hffff; endproperty
    a_vec_lo: assert property (p_vec_lo) else $error("no low vector read");
    property p_rst_run; $rose(rstn) |-> hreadyout && !memWe && lowPowerMode == 2'h0; endproperty
    a_rst_run: assert property (p_rst_run) else $error("bad state after reset");
    property p_ready; hsel && htrans[1] && hready |=> !hreadyout ##1 hreadyout; endproperty
    a_ready: assert property (p_ready) else $error("bad wait state");
    property p_hold; !$stable(hrdata) |-> hreadyout && !$past(hreadyout); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_excl; !(memRe && memWe); endproperty
    a_excl: assert property (p_excl) else $error("read and write together");
    property p_push; memWe && $past(memWe) |-> memAddr == $past(memAddr) - 16'h1; endproperty
    a_push: assert property (p_push) else $error("push address not decremented");
    property p_lp; lowPowerMode != 2'h3; endproperty
    a_lp: assert property (p_lp) else $error("illegal power mode");
endmodule // cpurf_core_monitor

bind cpurf_core cpurf_core_monitor i_cpurf_core_monitor (.core_clk(core_clk), .rstn(rstn),
    .hsel(hsel), .htrans(htrans), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
    .memAddr(memAddr), .memRe(memRe), .memWe(memWe), .lowPowerMode(lowPowerMode));

// >>> tb/tb_cpurf_core.sv
// Self-checking bench for the CPU register file
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb_cpurf_core
    import cpurf_pkg::*;
;
    logic        core_clk = 1'b0;
    logic        rstn     = 1'b0;
    logic        hsel     = 1'b0;
    logic [31:0] haddr    = 32'h0;
    logic [1:0]  htrans   = 2'h0, lowPowerMode;
    logic        hwrite   = 1'b0;
    logic [31:0] hwdata   = 32'h0;
    logic [31:0] hrdata, rd;
    logic        hreadyout, hresp;
    logic [7:0]  memRdata, memWdata;
    logic [15:0] memAddr;
    logic        memRe, memWe;
    int          error_cnt = 0, checks = 0, cyc = 0;

    cpurf_core i_cpurf_core (.core_clk(core_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .memRdata(memRdata),
        .memAddr(memAddr), .memWdata(memWdata), .memRe(memRe), .memWe(memWe),
        .lowPowerMode(lowPowerMode));
    cpurf_mem_model i_cpurf_mem_model (.core_clk(core_clk), .memAddr(memAddr),
        .memWdata(memWdata), .memRe(memRe), .memWe(memWe), .memRdata(memRdata));

    // Clock and hang guard
    always #50 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // One single AHB-Lite word transfer; read data lands in rd
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        `CHK("hresp", 1'b0, hresp)
    endtask

    task automatic idle();
        for (int i = 0; i < 30; i++) begin
            xfer(8'h18, 1'b0, 32'h0);
            if (rd[0] === 1'b0) break;
        end
    endtask

    task automatic cmd(input logic [5:0] op, input logic [15:0] opd);
        xfer(8'h14, 1'b1, {opd, 10'h0, op});
        idle();
    endtask

    task automatic chk_rd(input string n, input logic [7:0] a, input logic [31:0] e);
        xfer(a, 1'b0, 32'h0);
        `CHK(n, e, rd)
    endtask

    task automatic rst();
        rstn <= 1'b0;
        repeat (4) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        idle();
    endtask

    task automatic t_reset();
        chk_rd("pc", 8'h0c, 32'h2000);
        chk_rd("sp", 8'h08, 32'h00ff);
        chk_rd("flags", 8'h10, 32'h68);
        chk_rd("unmapped", 8'h1c, 32'h0);
        xfer(8'h00, 1'b1, 32'h5a);
        xfer(8'h04, 1'b1, 32'habcd);
        rst();
        chk_rd("acc", 8'h00, 32'h5a);
        chk_rd("index", 8'h04, 32'h00cd);
        $display("reset test done");
    endtask

    task automatic t_alu();
        logic [7:0] opd [3] = '{8'h08, 8'h78, 8'h88};
        logic [7:0] acc [3] = '{8'h10, 8'h88, 8'h10};
        logic [7:0] flg [3] = '{8'h78, 8'hec, 8'hf9};
        xfer(8'h00, 1'b1, 32'h08);
        for (int i = 0; i < 3; i++) begin
            cmd(OP_ADD, {8'h0, opd[i]});
            chk_rd("sum", 8'h00, {24'h0, acc[i]});
            chk_rd("flags", 8'h10, {24'h0, flg[i]});
        end
        cmd(OP_DAA, 16'h0);
        chk_rd("adjusted", 8'h00, 32'h76);
        xfer(8'h10, 1'b0, 32'h0);
        `CHK("carry", 1'b1, rd[0])
        xfer(8'h00, 1'b1, 32'h0);
        cmd(OP_ADD, 16'h0);
        chk_rd("zero", 8'h10, 32'h6a);
        xfer(8'h10, 1'b1, 32'h0);
        chk_rd("ones", 8'h10, 32'h60);
        $display("alu test done");
    endtask

    task automatic t_idx();
        cpurf_op_e op [7] = '{OP_COMX, OP_NEGX, OP_LSLX, OP_RORX, OP_INCX, OP_DECX, OP_CLRX};
        logic [7:0] ex [7] = '{8'h7e, 8'h82, 8'h04, 8'h82, 8'h83, 8'h82, 8'h00};
        xfer(8'h04, 1'b1, 32'h1281);
        for (int i = 0; i < 7; i++) begin
            cmd(op[i], 16'h0);
            chk_rd("index", 8'h04, {16'h0, 8'h12, ex[i]});
        end
        $display("index test done");
    endtask

    task automatic t_stack();
        cpurf_op_e op [3] = '{OP_AIS, OP_AIS, OP_RSP};
        logic [7:0] im [3] = '{8'hfe, 8'h05, 8'h00};
        logic [15:0] ex [3] = '{16'h047e, 16'h0483, 16'h04ff};
        xfer(8'h08, 1'b1, 32'h0480);
        for (int i = 0; i < 3; i++) begin
            cmd(op[i], {8'h0, im[i]});
            chk_rd("stack", 8'h08, {16'h0, ex[i]});
        end
        xfer(8'h00, 1'b1, 32'h3c);
        cmd(OP_PSHA, 16'h0);
        `CHK("pushed", 8'h3c, i_cpurf_mem_model.mem[16'h04ff])
        chk_rd("stack", 8'h08, 32'h04fe);
        xfer(8'h00, 1'b1, 32'h0);
        cmd(OP_PULA, 16'h0);
        chk_rd("pulled", 8'h00, 32'h3c);
        $display("stack test done");
    endtask

    task automatic t_flow();
        cpurf_op_e op [3] = '{OP_WAIT, OP_STOP, OP_NOP};
        xfer(8'h0c, 1'b1, 32'h2000);
        cmd(OP_FETCH, 16'h0);
        chk_rd("pc", 8'h0c, 32'h2001);
        xfer(8'h18, 1'b0, 32'h0);
        `CHK("fetched", 8'ha5, rd[15:8])
        cmd(OP_CALL, 16'h3456);
        chk_rd("pc", 8'h0c, 32'h3456);
        `CHK("ret low", 8'h01, i_cpurf_mem_model.mem[16'h04ff])
        `CHK("ret high", 8'h20, i_cpurf_mem_model.mem[16'h04fe])
        cmd(OP_RTS, 16'h0);
        chk_rd("pc", 8'h0c, 32'h2001);
        chk_rd("sp", 8'h08, 32'h04ff);
        xfer(8'h10, 1'b1, 32'h80);
        cmd(OP_BSG, 16'h0010);
        cmd(OP_BSL, 16'h00fe);
        chk_rd("branch", 8'h0c, 32'h1fff);
        for (int i = 0; i < 3; i++) begin
            cmd(op[i], 16'h0);
            `CHK("power", 2'(i % 3 == 2 ? 0 : i + 1), lowPowerMode)
        end
        $display("flow test done");
    endtask

    // Main sequence
    initial begin
        i_cpurf_mem_model.mem[16'hfffe] = 8'h20;
        i_cpurf_mem_model.mem[16'hffff] = 8'h00;
        i_cpurf_mem_model.mem[16'h2000] = 8'ha5;
        rst();
        t_reset();
        t_alu();
        t_idx();
        t_stack();
        t_flow();
        complete_run();
    end
endmodule // tb_cpurf_core
